/* File: common/mrw_pkg.sv */
// Constants shared by the Modbus RTU write handler
package mrw_pkg;
    // System clock and serial character format
    localparam longint CLK_HZ = 64'd10_000_000;
    localparam longint DEF_BAUD = 64'd9600;
    localparam longint CHAR_BITS = 64'd11;
    // Idle gap in tenths of a character time (3.5 chars)
    localparam longint GAP_TENTHS = 64'd35;
    // Least gap, rounded up to whole clock cycles
    localparam longint GAP_CYC_DEF =
        (GAP_TENTHS * CHAR_BITS * CLK_HZ + 64'd10 * DEF_BAUD - 64'd1) /
        (64'd10 * DEF_BAUD);
    localparam int GAP_W = 20;
    // Function codes
    localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
    // Frame layout
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam int FRAME_MAX = 32;
    localparam logic [5:0] LEN_SINGLE = 6'h08;
    localparam logic [5:0] LEN_MULTI_BASE = 6'h09;
    localparam logic [3:0] MAX_BLOCK = 4'h8;
    localparam logic [4:0] MULTI_DATA_POS = 5'h07;
    localparam logic [3:0] RESP_HDR_LEN = 4'h6;
    // CRC-16, reflected polynomial
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam int TX_DEPTH = 32;
    typedef enum logic [1:0] {ST_RX, ST_CHK, ST_WR, ST_TX} mrw_state_t;
endpackage

/* File: common/mrw_stream_if.sv */
// Valid/ready byte stream between the handler and its FIFO
`timescale 1ns/1ps
interface mrw_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface // mrw_stream_if

/* File: hdl/mrw_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module mrw_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Streams
    mrw_stream_if.snk in_s,
    mrw_stream_if.src out_s
);
    localparam int PW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
            $error("mrw_fifo: DEPTH must be a power of two >= 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW:0] wr;
        logic [PW:0] rd;
    } mrw_fifo_t;

    mrw_fifo_t s_q, s_d;
    logic full, empty;

    assign full = (s_q.wr[PW] != s_q.rd[PW]) &&
                  (s_q.wr[PW-1:0] == s_q.rd[PW-1:0]);
    assign empty = (s_q.wr == s_q.rd);
    assign in_s.ready = !full;
    assign out_s.valid = !empty;
    assign out_s.data = s_q.mem[s_q.rd[PW-1:0]];

    always_comb begin
        s_d = s_q;
        if (in_s.valid && !full) begin
            s_d.mem[s_q.wr[PW-1:0]] = in_s.data;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (out_s.ready && !empty) begin
            s_d.rd = s_q.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // mrw_fifo

/* File: hdl/mrw_handler.sv */
// Modbus RTU slave handler for write-register requests
// What this block does
// - Code 06 writes one 16-bit value at the given address, then replies.
// - Code 16 writes consecutive registers, at most 8 per request.
// - Request address equals parameter number, zero based, no offset.
// - Parameters are reachable only as holding registers.
// - Frames are separated by at least 3.5 character times of silence.
// - No start or end byte; only idle timing frames a message.
// - First character after a qualifying gap is the slave address byte.
// - Requests and replies start with slave address; broadcast zero ignored.
// - Frames end with CRC-16, low byte first then high byte.
// - Characters are 8 data bits, parity odd or even, one stop bit.
`timescale 1ns/1ps
module mrw_handler
    import mrw_pkg::*;
#(
    parameter int NREG = 256,
    parameter int GAP_CYCLES = int'(mrw_pkg::GAP_CYC_DEF)
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Configuration
    input wire logic [7:0] slave_addr_i,
    // Received characters from the UART
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_err_i,
    // Characters to the UART transmitter
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    // Holding register write notice
    output logic reg_we_o,
    output logic [15:0] reg_addr_o,
    output logic [15:0] reg_data_o,
    // Holding register read port
    input wire logic [15:0] rd_addr_i,
    output logic [15:0] rd_data_o
);
    import mrw_pkg::*;

    localparam int AW = $clog2(NREG);

    generate
        if (NREG < 2 || NREG > 65536) begin : g_bad_nreg
            $error("mrw_handler: NREG must lie in 2..65536");
        end
        if (GAP_CYCLES < 1 || GAP_CYCLES >= (1 << GAP_W)) begin : g_bad_gap
            $error("mrw_handler: GAP_CYCLES out of counter range");
        end
    endgenerate

    typedef struct packed {
        mrw_state_t st;
        logic [GAP_W-1:0] gap;
        logic [5:0] cnt;
        logic bad;
        logic junk;
        logic [15:0] crc;
        logic [FRAME_MAX-1:0][7:0] buff;
        logic [3:0] idx;
        logic [15:0] tcrc;
        logic [NREG-1:0][15:0] regs;
        logic we;
        logic [15:0] waddr;
        logic [15:0] wdata;
        logic [15:0] rdat;
        logic tx_valid;
        logic [7:0] tx_data;
    } mrw_state_s_t;

    mrw_state_s_t s_q, s_d;

    mrw_stream_if #(.W(8)) push_s ();
    mrw_stream_if #(.W(8)) pop_s ();

    mrw_fifo #(
        .W(8),
        .DEPTH(TX_DEPTH)
    ) u_tx_fifo (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .in_s(push_s),
        .out_s(pop_s)
    );

    function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // Decoded request fields
    logic [7:0] fcode;
    logic [15:0] start, qty;
    logic [16:0] last_reg;
    logic gap_done, frame_ok, is_single, multi_ok;
    logic [4:0] dpos;
    logic [3:0] nwr;

    assign fcode = s_q.buff[1];
    assign start = {s_q.buff[2], s_q.buff[3]};
    assign qty = {s_q.buff[4], s_q.buff[5]};
    assign last_reg = {1'b0, start} + {1'b0, qty};
    assign is_single = (fcode == FC_WRITE_SINGLE);
    assign gap_done = (s_q.gap >= GAP_W'(GAP_CYCLES));
    assign dpos = MULTI_DATA_POS + {s_q.idx, 1'b0};
    assign nwr = is_single ? 4'h1 : qty[3:0];

    assign multi_ok = (fcode == FC_WRITE_MULTI) && qty != 16'h0000 &&
        qty <= {12'h000, MAX_BLOCK} &&
        s_q.buff[6] == {qty[6:0], 1'b0} &&
        s_q.cnt == LEN_MULTI_BASE + {qty[4:0], 1'b0} &&
        last_reg <= 17'(NREG);

    always_comb begin
        frame_ok = !s_q.bad && s_q.buff[0] == slave_addr_i &&
                   s_q.buff[0] != BCAST_ADDR;
        frame_ok = frame_ok && s_q.crc == 16'h0000;
        frame_ok = frame_ok && ((is_single && s_q.cnt == LEN_SINGLE &&
                   {1'b0, start} < 17'(NREG)) || multi_ok);
    end

    // Response: echo of the first six bytes, then CRC low, CRC high
    assign push_s.valid = (s_q.st == ST_TX);
    always_comb begin
        if (s_q.idx < RESP_HDR_LEN) begin
            push_s.data = s_q.buff[s_q.idx];
        end else if (s_q.idx == RESP_HDR_LEN) begin
            push_s.data = s_q.tcrc[7:0];
        end else begin
            push_s.data = s_q.tcrc[15:8];
        end
    end

    assign pop_s.ready = !s_q.tx_valid || tx_ready_i;

    always_comb begin
        s_d = s_q;
        s_d.we = 1'b0;
        s_d.rdat = s_q.regs[rd_addr_i[AW-1:0]];
        if ({1'b0, rd_addr_i} >= 17'(NREG)) begin
            s_d.rdat = 16'h0000;
        end

        // Output stage toward the transmitter
        if (pop_s.valid && pop_s.ready) begin
            s_d.tx_valid = 1'b1;
            s_d.tx_data = pop_s.data;
        end else if (tx_ready_i) begin
            s_d.tx_valid = 1'b0;
        end

        // idle timer is the only framing
        if (rx_valid_i) begin
            s_d.gap = '0;
        end else if (!gap_done) begin
            s_d.gap = s_q.gap + 1'b1;
        end

        case (s_q.st)
            ST_RX: begin
                if (rx_valid_i && !s_q.junk) begin
                    // first byte after gap opens a frame
                    if (s_q.cnt == 6'h00) begin
                        s_d.crc = crc_upd(CRC_INIT, rx_data_i);
                        s_d.bad = 1'b0;
                    end else begin
                        s_d.crc = crc_upd(s_q.crc, rx_data_i);
                    end
                    if (s_q.cnt < 6'(FRAME_MAX)) begin
                        s_d.buff[s_q.cnt[4:0]] = rx_data_i;
                        s_d.cnt = s_q.cnt + 1'b1;
                    end else begin
                        s_d.bad = 1'b1;
                    end
                    // parity or framing error spoils frame
                    if (rx_err_i) begin
                        s_d.bad = 1'b1;
                    end
                end else if (!rx_valid_i && gap_done) begin
                    s_d.junk = 1'b0;
                    if (s_q.cnt != 6'h00 && !s_q.junk) begin
                        s_d.st = ST_CHK;
                    end
                end
            end
            ST_CHK: begin
                s_d.idx = 4'h0;
                if (frame_ok) begin
                    s_d.st = ST_WR;
                end else begin
                    s_d.st = ST_RX;
                    s_d.cnt = 6'h00;
                end
            end
            ST_WR: begin
                s_d.waddr = start + {12'h000, s_q.idx};
                if (is_single) begin
                    s_d.wdata = qty;
                end else begin
                    s_d.wdata = {s_q.buff[dpos], s_q.buff[dpos + 5'h01]};
                end
                s_d.regs[s_d.waddr[AW-1:0]] = s_d.wdata;
                s_d.we = 1'b1;
                s_d.idx = s_q.idx + 1'b1;
                if (s_q.idx == nwr - 4'h1) begin
                    s_d.st = ST_TX;
                    s_d.idx = 4'h0;
                    s_d.tcrc = CRC_INIT;
                end
            end
            ST_TX: begin
                if (push_s.ready) begin
                    if (s_q.idx < RESP_HDR_LEN) begin
                        s_d.tcrc = crc_upd(s_q.tcrc, push_s.data);
                    end
                    s_d.idx = s_q.idx + 1'b1;
                    if (s_q.idx == RESP_HDR_LEN + 4'h1) begin
                        s_d.st = ST_RX;
                        s_d.cnt = 6'h00;
                    end
                end
            end
            default: begin
                s_d.st = ST_RX;
            end
        endcase

        // Bytes heard while busy belong to no frame we can serve
        if (rx_valid_i && s_q.st != ST_RX) begin
            s_d.junk = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tx_valid_o = s_q.tx_valid;
    assign tx_data_o = s_q.tx_data;
    assign reg_we_o = s_q.we;
    assign reg_addr_o = s_q.waddr;
    assign reg_data_o = s_q.wdata;
    assign rd_data_o = s_q.rdat;
endmodule // mrw_handler

/* File: bench/mrw_handler_monitor.sv */
// Port checker for the Modbus RTU write handler
`timescale 1ns/1ps
module mrw_handler_mon #(
    parameter int NREG = 256,
    parameter int GAP_CYCLES = 20
) (
    // Watched ports
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic rx_valid_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic reg_we_o,
    input wire logic [15:0] reg_addr_o
);
    logic [31:0] idle_q;
    logic [3:0] run_q;
    // Idle edges since the last character, earlier writes in the current burst
    always_ff @(posedge clk_i) begin
        if (srst_i || rx_valid_i) idle_q <= 32'h0;
        else if (idle_q != 32'hffffffff) idle_q <= idle_q + 32'h1;
        if (srst_i || !reg_we_o) run_q <= 4'h0;
        else if (run_q != 4'hf) run_q <= run_q + 4'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    write_gap_a: assert property (
        $rose(reg_we_o) |-> idle_q >= 32'(GAP_CYCLES))
        else $error("write before the idle gap");
    reply_gap_a: assert property (
        $rose(tx_valid_o) |-> idle_q >= 32'(GAP_CYCLES))
        else $error("reply before the idle gap");
    burst_limit_a: assert property (reg_we_o |-> run_q < 4'h8)
        else $error("more than eight writes in a burst");
    addr_step_a: assert property (
        reg_we_o && $past(reg_we_o) |->
            reg_addr_o == $past(reg_addr_o) + 16'h1)
        else $error("burst address not consecutive");
    addr_range_a: assert property (reg_we_o |-> reg_addr_o < 16'(NREG))
        else $error("write outside the register space");
    tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o)
        else $error("reply byte withdrawn");
    tx_data_a: assert property (
        tx_valid_o && !tx_ready_i |=> $stable(tx_data_o))
        else $error("reply byte changed while waiting");
    store_first_a: assert property (reg_we_o |-> !tx_valid_o)
        else $error("reply overlaps the store");
endmodule // mrw_handler_mon

bind mrw_handler mrw_handler_mon #(
    .NREG(NREG),
    .GAP_CYCLES(GAP_CYCLES)
) mon_u (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .rx_valid_i(rx_valid_i),
    .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready_i),
    .reg_we_o(reg_we_o),
    .reg_addr_o(reg_addr_o)
);

/* File: bench/mrw_master_model.sv */
// Serial master stand-in feeding requests and taking replies
`timescale 1ns/1ps
module mrw_master_model #(
    parameter int GAP_CYCLES = 20
) (
    // Clock
    input wire logic clk_i,
    // Request characters
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_err_o,
    // Reply characters
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o
);
    logic [7:0] got_q[$];
    logic slow = 1'b0;
    logic [1:0] cnt = 2'h0;
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        rx_err_o = 1'b0;
        tx_ready_o = 1'b1;
    end
    // Slow mode takes one reply byte in four cycles
    always @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o) got_q.push_back(tx_data_i);
        cnt <= cnt + 2'h1;
        tx_ready_o <= !slow || cnt == 2'h3;
    end
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    task automatic send(input logic [7:0] b[$], input logic bad,
                        input int err_at);
        logic [15:0] c;
        c = crc16(b) ^ {15'h0, bad};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        repeat (GAP_CYCLES + 2) @(posedge clk_i);
        foreach (b[i]) begin
            rx_valid_o <= 1'b1;
            rx_data_o <= b[i];
            rx_err_o <= (i == err_at);
            @(posedge clk_i);
        end
        rx_valid_o <= 1'b0;
        rx_err_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
    endtask
endmodule // mrw_master_model

/* File: bench/tb_modbus_rtu_slave_write_handler.sv */
// Self-checking bench for the Modbus RTU write handler
`timescale 1ns/1ps
module tb_modbus_rtu_slave_write_handler;
    import mrw_pkg::*;
    localparam int GAP = 20;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [15:0] rd_addr_i = 16'h0000;
    logic [7:0] own_addr = 8'h01;
    logic rx_valid, rx_err, tx_valid, tx_ready, reg_we;
    logic [7:0] rx_data, tx_data;
    logic [15:0] reg_addr, reg_data, rd_data;
    logic [31:0] wr_q[$];
    int bad_count = 0;
    int total_checks = 0;
    initial forever #50 clk_i = ~clk_i;
    mrw_handler #(.NREG(256), .GAP_CYCLES(GAP)) dut_u (
        .clk_i(clk_i), .srst_i(srst_i), .slave_addr_i(own_addr),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_err_i(rx_err),
        .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
        .reg_we_o(reg_we), .reg_addr_o(reg_addr), .reg_data_o(reg_data),
        .rd_addr_i(rd_addr_i), .rd_data_o(rd_data));
    mrw_master_model #(.GAP_CYCLES(GAP)) master_u (
        .clk_i(clk_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .rx_err_o(rx_err), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .tx_ready_o(tx_ready));
    always @(posedge clk_i) if (reg_we) wr_q.push_back({reg_addr, reg_data});
    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Sends one request, then judges writes, readback and reply
    task automatic run(input logic [7:0] b[$], input logic bad,
                       input int err_at, input logic good);
        logic [7:0] e[$];
        logic [15:0] c;
        logic [31:0] w;
        int n, k;
        wr_q.delete();
        master_u.got_q.delete();
        master_u.send(b, bad, err_at);
        n = 0;
        while (good && master_u.got_q.size() < 8 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        // A reply that never comes adds one mismatch here, the reply checks below add more, and the run moves on
        if (good && master_u.got_q.size() < 8) begin
            bad_count++;
        end
        repeat (good ? 4 : GAP + 60) @(posedge clk_i);
        check("reply length", master_u.got_q.size(), good ? 8 : 0);
        k = !good ? 0 : (b[1] == FC_WRITE_SINGLE) ? 1 : int'(b[5]);
        check("write count", wr_q.size(), k);
        if (good) begin
            e = b[0:5];
            c = master_u.crc16(e);
            e.push_back(c[7:0]);
            e.push_back(c[15:8]);
            foreach (e[i]) begin
                check("reply byte", master_u.got_q[i], e[i]);
            end
        end
        for (int i = 0; i < k; i++) begin
            w[31:16] = {b[2], b[3]} + 16'(i);
            w[15:0] = (b[1] == FC_WRITE_SINGLE) ? {b[4], b[5]} :
                {b[7+2*i], b[8+2*i]};
            check("write", wr_q[i], w);
            rd_addr_i <= w[31:16];
            repeat (2) @(posedge clk_i);
            check("readback", rd_data, {16'h0, w[15:0]});
        end
    endtask
    task automatic sc_single();
        logic [7:0] s[$];
        s = '{8'h01, FC_WRITE_SINGLE, 8'h00, 8'h0c, 8'h00, 8'h09};
        run(s, 1'b0, -1, 1'b1);
        // Another own address is answered under that address
        s = '{8'h20, FC_WRITE_SINGLE, 8'h00, 8'hff, 8'h12, 8'h34};
        own_addr <= 8'h20;
        run(s, 1'b0, -1, 1'b1);
        own_addr <= 8'h01;
    endtask
    task automatic sc_multi();
        logic [7:0] b[$];
        b = '{8'h01, FC_WRITE_MULTI, 8'h00, 8'h00, 8'h00, 8'h08, 8'h10};
        for (int i = 0; i < 16; i++) b.push_back(8'(8'ha0 + i));
        master_u.slow <= 1'b1;
        run(b, 1'b0, -1, 1'b1);
        master_u.slow <= 1'b0;
    endtask
    task automatic sc_drops();
        logic [7:0] b[$];
        logic [7:0] s[$];
        s = '{8'h01, FC_WRITE_SINGLE, 8'h00, 8'h01, 8'h12, 8'h34};
        run(s, 1'b1, -1, 1'b0);
        run(s, 1'b0, 3, 1'b0);
        s[0] = 8'h02;
        run(s, 1'b0, -1, 1'b0);
        // Own address set to zero still must not take a broadcast
        s[0] = BCAST_ADDR;
        own_addr <= BCAST_ADDR;
        run(s, 1'b0, -1, 1'b0);
        own_addr <= 8'h01;
        s = '{8'h01, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01};
        run(s, 1'b0, -1, 1'b0);
        s = '{8'h01, FC_WRITE_SINGLE, 8'h01, 8'h00, 8'h12, 8'h34};
        run(s, 1'b0, -1, 1'b0);
        b = '{8'h01, FC_WRITE_MULTI, 8'h00, 8'h00, 8'h00, 8'h09, 8'h12};
        repeat (18) b.push_back(8'h55);
        run(b, 1'b0, -1, 1'b0);
    endtask
    task automatic sc_resync();
        run('{8'h01, FC_WRITE_SINGLE, 8'h00}, 1'b0, -1, 1'b0);
        run('{8'h01, FC_WRITE_SINGLE, 8'h00, 8'hff, 8'hff, 8'hff}, 1'b0, -1,
            1'b1);
    endtask
    // Mid-run reset clears the outputs and the holding registers
    task automatic sc_reset();
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        rd_addr_i <= 16'h00ff;
        repeat (2) @(posedge clk_i);
        check("reset strobes", {tx_valid, reg_we}, 32'h0);
        check("reset readback", rd_data, 32'h0);
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        sc_single();
        sc_multi();
        sc_drops();
        sc_resync();
        sc_reset();
        print_verdict();
    end
endmodule // tb_modbus_rtu_slave_write_handler
